/* design/ecc_corrector_pkg.sv */
// shared constants and types for the block error corrector
package ecc_corrector_pkg;

  // block layout
  localparam int unsigned PLANE_COUNT     = 2;
  localparam int unsigned PARITY_BYTES    = 2;
  localparam logic [5:0]  P_CODEWORDS     = 6'h2B;   // 43
  localparam logic [5:0]  Q_CODEWORDS     = 6'h1A;   // 26
  localparam logic [5:0]  P_LENGTH        = 6'h1A;   // 24 data + 2 parity
  localparam logic [5:0]  Q_LENGTH        = 6'h2D;   // 43 data + 2 parity
  localparam logic [11:0] P_STRIDE        = 12'h02B; // 43 words per P symbol row
  localparam logic [11:0] Q_STEP_SYM      = 12'h02C; // 44
  localparam logic [11:0] Q_STEP_CW       = 12'h02B; // 43
  localparam logic [11:0] Q_MODULUS       = 12'h45E; // 1118
  localparam logic [11:0] Q_PARITY0_BASE  = 12'h45E; // 1118
  localparam logic [11:0] Q_PARITY1_BASE  = 12'h478; // 1144
  localparam logic [5:0]  Q_PARITY0_SYM   = 6'h2B;   // 43
  localparam logic [5:0]  Q_PARITY1_SYM   = 6'h2C;   // 44
  localparam logic [15:0] HEADER_BYTES    = 16'h000C;
  localparam logic [11:0] CRC_SPAN        = 12'h814; // 2068 bytes incl. stored check

  // arithmetic
  localparam logic [7:0]  GF_POLY_LOW     = 8'h1D;
  localparam logic [31:0] CRC_POLY        = 32'hD8018001;
  localparam logic [31:0] CRC_INIT        = 32'h00000000;

  // buffer memory command
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_cmd_type;

  // completion status
  typedef struct packed {
    logic busy;
    logic done;
    logic uncorrectable;
    logic crcError;
  } ecc_status_type;

  localparam mem_cmd_type    MEM_CMD_RESET = '{req: 1'b0, we: 1'b0, addr: 16'h0000,
                                               wdata: 8'h00};
  localparam ecc_status_type STATUS_RESET  = '{busy: 1'b0, done: 1'b0,
                                               uncorrectable: 1'b0, crcError: 1'b0};

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_READ   = 7'h02,
    ST_LOCATE = 7'h04,
    ST_FIXRD  = 7'h08,
    ST_FIXWR  = 7'h10,
    ST_CRC    = 7'h20,
    ST_DONE   = 7'h40
  } ecc_state_type;

endpackage

/* design/ecc_symbol_address.sv */
// byte address of one codeword symbol within the buffered block
`timescale 1ns/1ns
module ecc_symbol_address
  import ecc_corrector_pkg::*;
(
  // symbol selection
  input  wire logic        dirQ,
  input  wire logic        plane,
  input  wire logic [5:0]  codeword,
  input  wire logic [5:0]  symbol,
  input  wire logic [15:0] blockBase,
  // result
  output logic [15:0]      symAddr
);

  logic [11:0] wordIdx;

  always_comb
  begin
    wordIdx = 12'h000;
    if (!dirQ)
    begin
      wordIdx = P_STRIDE * {6'h00, symbol} + {6'h00, codeword};
    end
    else if (symbol == Q_PARITY0_SYM)
    begin
      wordIdx = Q_PARITY0_BASE + {6'h00, codeword};
    end
    else if (symbol == Q_PARITY1_SYM)
    begin
      wordIdx = Q_PARITY1_BASE + {6'h00, codeword};
    end
    else
    begin
      // diagonal walk, wrapped twice at most
      wordIdx = Q_STEP_SYM * {6'h00, symbol} + Q_STEP_CW * {6'h00, codeword};
      if (wordIdx >= Q_MODULUS)
      begin
        wordIdx = wordIdx - Q_MODULUS;
      end
      if (wordIdx >= Q_MODULUS)
      begin
        wordIdx = wordIdx - Q_MODULUS;
      end
    end
    symAddr = blockBase + HEADER_BYTES + {3'b000, wordIdx, plane};
  end

endmodule

/* design/cdrom_block_error_corrector.sv */
// single-error corrector and check pass for a buffered data block
`timescale 1ns/1ns
// Operation
// - each block is two planes, each with 43 P and 26 Q codewords
// - two parity bytes per codeword give syndromes S0 and S1
// - at most one byte per codeword is repaired, otherwise flagged
// - Reed-Solomon decoding runs fully in hardware, no per-byte software help
// - default pass order is all Q codewords, then all P codewords
// - check sum is computed over corrected block contents after correction
// - new passes start while buffer controller keeps storing disc data
module cdrom_block_error_corrector
  import ecc_corrector_pkg::*;
(
  // clock and reset
  input  wire logic           clk_sys,
  input  wire logic           sys_rst,
  // control from microcontroller logic
  input  wire logic           start,
  input  wire logic           pFirst,
  input  wire logic [15:0]    blockBase,
  // buffer memory port
  output mem_cmd_type         memCmd,
  input  wire logic           memAck,
  input  wire logic [7:0]     memRdata,
  // status
  output ecc_status_type      status
);

  ecc_state_type  state_q,  state_d;
  mem_cmd_type    cmd_q,    cmd_d;
  ecc_status_type stat_q,   stat_d;
  logic           dirQ_q,   dirQ_d;
  logic           second_q, second_d;
  logic           plane_q,  plane_d;
  logic [5:0]     cw_q,     cw_d;
  logic [5:0]     sym_q,    sym_d;
  logic [5:0]     k_q,      k_d;
  logic [7:0]     s0_q,     s0_d;
  logic [7:0]     s1_q,     s1_d;
  logic [7:0]     t_q,      t_d;
  logic [7:0]     fix_q,    fix_d;
  logic [11:0]    crcIdx_q, crcIdx_d;
  logic [31:0]    crc_q,    crc_d;
  logic [15:0]    base_q,   base_d;
  logic [15:0]    symAddr;
  logic [5:0]     cwLen;
  logic [5:0]     cwCount;
  logic           lastCw;

  function automatic logic [7:0] mulAlpha(input logic [7:0] x);
    mulAlpha = {x[6:0], 1'b0} ^ (x[7] ? GF_POLY_LOW : 8'h00);
  endfunction

  function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    crcByte = r;
  endfunction

  ecc_symbol_address u_addr (
    .dirQ      (dirQ_q),
    .plane     (plane_q),
    .codeword  (cw_q),
    .symbol    (sym_q),
    .blockBase (base_q),
    .symAddr   (symAddr)
  );

  assign cwLen   = dirQ_q ? Q_LENGTH : P_LENGTH;
  assign cwCount = dirQ_q ? Q_CODEWORDS : P_CODEWORDS;
  assign lastCw  = (cw_q == cwCount - 6'h01) && plane_q;

  always_comb
  begin
    state_d  = state_q;
    cmd_d    = cmd_q;
    stat_d   = stat_q;
    dirQ_d   = dirQ_q;
    second_d = second_q;
    plane_d  = plane_q;
    cw_d     = cw_q;
    sym_d    = sym_q;
    k_d      = k_q;
    s0_d     = s0_q;
    s1_d     = s1_q;
    t_d      = t_q;
    fix_d    = fix_q;
    crcIdx_d = crcIdx_q;
    crc_d    = crc_q;
    base_d   = base_q;
    stat_d.done = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (start)
        begin
          base_d      = blockBase;
          dirQ_d      = !pFirst;
          second_d    = 1'b0;
          plane_d     = 1'b0;
          cw_d        = 6'h00;
          sym_d       = 6'h00;
          s0_d        = 8'h00;
          s1_d        = 8'h00;
          stat_d      = STATUS_RESET;
          stat_d.busy = 1'b1;
          state_d     = ST_READ;
        end
      end
      ST_READ:
      begin
        if (!cmd_q.req)
        begin
          cmd_d.req  = 1'b1;
          cmd_d.we   = 1'b0;
          cmd_d.addr = symAddr;
        end
        else if (memAck)
        begin
          cmd_d.req = 1'b0;
          s0_d      = s0_q ^ memRdata;
          s1_d      = mulAlpha(s1_q) ^ memRdata;
          if (sym_q == cwLen - 6'h01)
          begin
            k_d     = 6'h00;
            t_d     = s0_q ^ memRdata;
            state_d = ST_LOCATE;
          end
          else
          begin
            sym_d = sym_q + 6'h01;
          end
        end
      end
      ST_LOCATE:
      begin
        // t walks S0*alpha^k until it meets S1
        if ((s0_q == 8'h00) && (s1_q == 8'h00))
        begin
          state_d = ST_DONE;
        end
        else if ((s0_q == 8'h00) || (s1_q == 8'h00))
        begin
          stat_d.uncorrectable = 1'b1;
          state_d              = ST_DONE;
        end
        else if (t_q == s1_q)
        begin
          sym_d   = cwLen - 6'h01 - k_q;
          state_d = ST_FIXRD;
        end
        else if (k_q == cwLen - 6'h01)
        begin
          stat_d.uncorrectable = 1'b1;
          state_d              = ST_DONE;
        end
        else
        begin
          t_d = mulAlpha(t_q);
          k_d = k_q + 6'h01;
        end
      end
      ST_FIXRD:
      begin
        if (!cmd_q.req)
        begin
          cmd_d.req  = 1'b1;
          cmd_d.we   = 1'b0;
          cmd_d.addr = symAddr;
        end
        else if (memAck)
        begin
          cmd_d.req   = 1'b0;
          fix_d       = memRdata ^ s0_q;
          state_d     = ST_FIXWR;
        end
      end
      ST_FIXWR:
      begin
        if (!cmd_q.req)
        begin
          cmd_d.req   = 1'b1;
          cmd_d.we    = 1'b1;
          cmd_d.wdata = fix_q;
        end
        else if (memAck)
        begin
          cmd_d.req = 1'b0;
          cmd_d.we  = 1'b0;
          state_d   = ST_DONE;
        end
      end
      ST_DONE:
      begin
        // advance to next codeword, plane and direction
        sym_d   = 6'h00;
        s0_d    = 8'h00;
        s1_d    = 8'h00;
        state_d = ST_READ;
        if (cw_q != cwCount - 6'h01)
        begin
          cw_d = cw_q + 6'h01;
        end
        else
        begin
          cw_d    = 6'h00;
          plane_d = !plane_q;
        end
        if (lastCw)
        begin
          if (!second_q)
          begin
            second_d = 1'b1;
            dirQ_d   = !dirQ_q;
          end
          else
          begin
            crcIdx_d = 12'h000;
            crc_d    = CRC_INIT;
            state_d  = ST_CRC;
          end
        end
      end
      ST_CRC:
      begin
        if (!cmd_q.req)
        begin
          cmd_d.req  = 1'b1;
          cmd_d.we   = 1'b0;
          cmd_d.addr = base_q + {4'h0, crcIdx_q};
        end
        else if (memAck)
        begin
          cmd_d.req = 1'b0;
          crc_d     = crcByte(crc_q, memRdata);
          if (crcIdx_q == CRC_SPAN - 12'h001)
          begin
            stat_d.crcError = (crcByte(crc_q, memRdata) != 32'h00000000);
            stat_d.done     = 1'b1;
            stat_d.busy     = 1'b0;
            state_d         = ST_IDLE;
          end
          else
          begin
            crcIdx_d = crcIdx_q + 12'h001;
          end
        end
      end
      default:
      begin
        state_d = ST_IDLE;
        cmd_d   = MEM_CMD_RESET;
        stat_d  = STATUS_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_q  <= ST_IDLE;
      cmd_q    <= MEM_CMD_RESET;
      stat_q   <= STATUS_RESET;
      dirQ_q   <= 1'b1;
      second_q <= 1'b0;
      plane_q  <= 1'b0;
      cw_q     <= 6'h00;
      sym_q    <= 6'h00;
      k_q      <= 6'h00;
      s0_q     <= 8'h00;
      s1_q     <= 8'h00;
      t_q      <= 8'h00;
      fix_q    <= 8'h00;
      crcIdx_q <= 12'h000;
      crc_q    <= CRC_INIT;
      base_q   <= 16'h0000;
    end
    else
    begin
      state_q  <= state_d;
      cmd_q    <= cmd_d;
      stat_q   <= stat_d;
      dirQ_q   <= dirQ_d;
      second_q <= second_d;
      plane_q  <= plane_d;
      cw_q     <= cw_d;
      sym_q    <= sym_d;
      k_q      <= k_d;
      s0_q     <= s0_d;
      s1_q     <= s1_d;
      t_q      <= t_d;
      fix_q    <= fix_d;
      crcIdx_q <= crcIdx_d;
      crc_q    <= crc_d;
      base_q   <= base_d;
    end
  end

  assign memCmd = cmd_q;
  assign status = stat_q;

endmodule

/* verification/ecc_corrector_assertions.sv */
// port assertions for the block corrector
`timescale 1ns/1ns
module ecc_corrector_assertions
  import ecc_corrector_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // control
  input wire logic        start,
  input wire logic        pFirst,
  input wire logic [15:0] blockBase,
  // memory port
  input mem_cmd_type      memCmd,
  input wire logic        memAck,
  input wire logic [7:0]  memRdata,
  // status
  input ecc_status_type   status
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  property p_reqHold;
    memCmd.req && !memAck |=> memCmd.req && $stable(memCmd);
  endproperty
  a_reqHold: assert property (p_reqHold)
    else $error("request changed before ack");

  property p_reqDrop;
    memCmd.req && memAck |=> !memCmd.req;
  endproperty
  a_reqDrop: assert property (p_reqDrop)
    else $error("request not released after ack");

  property p_startBusy;
    !status.busy && start |=> status.busy;
  endproperty
  a_startBusy: assert property (p_startBusy)
    else $error("start in idle not taken");

  property p_firstRead;
    !status.busy && start |-> ##2 memCmd.req && !memCmd.we
      && memCmd.addr == $past(blockBase, 2) + 16'h000C;
  endproperty
  a_firstRead: assert property (p_firstRead)
    else $error("first read not at symbol zero");

  property p_donePulse;
    status.done |-> !status.busy ##1 !status.done;
  endproperty
  a_donePulse: assert property (p_donePulse)
    else $error("done not a single idle cycle");

  property p_flagsClear;
    !status.busy && start |=> !status.uncorrectable && !status.crcError;
  endproperty
  a_flagsClear: assert property (p_flagsClear)
    else $error("flags not cleared on start");

  property p_flagsHold;
    !status.busy && !start |=> $stable({status.uncorrectable, status.crcError});
  endproperty
  a_flagsHold: assert property (p_flagsHold)
    else $error("flags changed while idle");

  property p_memIdle;
    !status.busy |-> !memCmd.req;
  endproperty
  a_memIdle: assert property (p_memIdle)
    else $error("memory access while idle");
endmodule

/* verification/buffer_ram_model.sv */
// buffer memory model answering byte requests
`timescale 1ns/1ns
module buffer_ram_model
  import ecc_corrector_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  // latency select
  input wire logic       slow,
  // memory port
  input mem_cmd_type     memCmd,
  output logic           memAck = 1'b0,
  output logic [7:0]     memRdata = 8'h00
);
  logic [7:0] mem [0:4095];
  logic       waitQ;
  int         nWrites = 0;

  // one access at a time, ack after one or two cycles
  always @(posedge clk_sys)
  begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (sys_rst)
      waitQ <= 1'b0;
    else if (memCmd.req && !memAck)
    begin
      waitQ <= slow && !waitQ;
      if (!slow || waitQ)
      begin
        memAck <= 1'b1;
        if (memCmd.we)
        begin
          mem[memCmd.addr[11:0]] <= memCmd.wdata;
          nWrites <= nWrites + 1;
        end
        else
          memRdata <= mem[memCmd.addr[11:0]];
      end
    end
  end
endmodule

/* verification/testbench.sv */
// testbench for the block corrector
`timescale 1ns/1ns
module testbench
  import ecc_corrector_pkg::*;
;
  logic           clk_sys;
  logic           sys_rst;
  logic           start;
  logic           pFirst;
  logic           slow;
  logic           memAck;
  logic [7:0]     memRdata;
  mem_cmd_type    memCmd;
  ecc_status_type status;
  int             nErrors = 0;
  int             totalChecks = 0;

  cdrom_block_error_corrector uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .start(start),
    .pFirst(pFirst), .blockBase(16'h0100), .memCmd(memCmd), .memAck(memAck),
    .memRdata(memRdata), .status(status));
  buffer_ram_model model (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow),
    .memCmd(memCmd), .memAck(memAck), .memRdata(memRdata));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    totalChecks++;
    if (got !== exp)
    begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic clear_mem();
    for (int a = 0; a < 4096; a++)
      model.mem[a] = 8'h00;
  endtask

  // one block pass, judged at the done cycle
  task automatic run_block(input logic ord, input logic sl, input logic eu, input logic ec,
                           input int ew);
    int w0;
    int i;
    w0 = model.nWrites;
    @(posedge clk_sys);
    start <= 1'b1;
    pFirst <= ord;
    slow <= sl;
    @(posedge clk_sys);
    start <= 1'b0;
    i = 0;
    do
    begin
      @(negedge clk_sys);
      i++;
    end while (status.done !== 1'b1 && i < 40000);
    check("done", 8'h01, {7'h00, status.done});
    check("busy", 8'h00, {7'h00, status.busy});
    check("uncorrectable", {7'h00, eu}, {7'h00, status.uncorrectable});
    check("crcError", {7'h00, ec}, {7'h00, status.crcError});
    check("writes", 8'(ew), 8'(model.nWrites - w0));
  endtask

  task automatic test_q_first();
    clear_mem();
    model.mem[12'h10C] = 8'h01;
    model.mem[12'h164] = 8'h01;
    run_block(1'b0, 1'b0, 1'b1, 1'b0, 2);
    check("byte 10C", 8'h00, model.mem[12'h10C]);
    check("byte 164", 8'h00, model.mem[12'h164]);
  endtask

  task automatic test_repeat();
    run_block(1'b0, 1'b0, 1'b0, 1'b0, 0);
  endtask

  task automatic test_p_first();
    clear_mem();
    model.mem[12'h10C] = 8'h01;
    model.mem[12'h164] = 8'h01;
    model.mem[12'h9C7] = 8'h5A;
    model.mem[12'h9FD] = 8'hC3;
    run_block(1'b1, 1'b0, 1'b0, 1'b0, 4);
    check("byte 10C", 8'h00, model.mem[12'h10C]);
    check("byte 164", 8'h00, model.mem[12'h164]);
    check("byte 9C7", 8'h00, model.mem[12'h9C7]);
    check("byte 9FD", 8'h00, model.mem[12'h9FD]);
  endtask

  task automatic test_square();
    clear_mem();
    model.mem[12'h10C] = 8'h01;
    model.mem[12'h164] = 8'h01;
    model.mem[12'h162] = 8'h01;
    model.mem[12'h1BA] = 8'h01;
    run_block(1'b0, 1'b1, 1'b1, 1'b1, 0);
    check("byte 162", 8'h01, model.mem[12'h162]);
  endtask

  task automatic stopTest();
    $display("checks %0d mismatches %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (95000) @(posedge clk_sys);
    nErrors++;
    stopTest();
  end

  initial
  begin
    sys_rst = 1'b1;
    start = 1'b0;
    pFirst = 1'b0;
    slow = 1'b0;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    test_q_first();
    test_repeat();
    test_p_first();
    test_square();
    stopTest();
  end
endmodule

bind cdrom_block_error_corrector ecc_corrector_assertions chk (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .start(start), .pFirst(pFirst), .blockBase(blockBase),
  .memCmd(memCmd), .memAck(memAck), .memRdata(memRdata), .status(status));
